// ===== design/jumper_option_consts.vh
`ifndef JUMPER_OPTION_CONSTS_VH
`define JUMPER_OPTION_CONSTS_VH
// Target ID width and range
`define ID_WIDTH 4
// Spin-up delay multipliers, in seconds per ID step
`define MULT_ZERO 4'h0
`define MULT_TEN 4'ha
`define MULT_FOUR 4'h4
// Connector variants
`define VARIANT_68 1'b0
`define VARIANT_80 1'b1
// One second at 125 MHz
`define CLOCK_HZ 125000000
`define SECOND_CYCLES 125000000
// States of the spin-up sequencer
`define SPIN_IDLE 2'h0
`define SPIN_WAIT 2'h1
`define SPIN_RUN 2'h2
`define SPIN_STOP 2'h3
// Last settle count before the straps are latched
`define SETTLE_LAST 2'h3
`endif

// ===== design/strap_sync.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-stage synchroniser for a group of strap pins
// ----------------------------------------------------------------
module strap_sync #(
	parameter WIDTH = 12
) (
	input wire clock,
	input wire nrst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] stage1;
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stage1 <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule // strap_sync

// ===== design/jumper_option_decoder.v
`timescale 1ns/1ps
`include "jumper_option_consts.vh"
// Summary of operation
// - Four ID straps give unsigned ID 0-15
// - Auto mode starts motor without start command
// - Otherwise motor waits for start unit
// - Auto delay equals multiplier times own ID
// - 68-pin: none, start 0, delay 10, both 4
// - 80-pin: none 0, start off, delay 10
// - Write-protect refuses media-modifying commands
// - Write-protect sampled anew per command
// - Negotiation strap stops target-initiated negotiation
// - Parity strap disables parity checking, flagging
// - Attention strap suppresses reset Unit Attention
// - Attention strap discards pending Unit Attention
// - Auxiliary spin pin is input, low enables auto spin-up on 68-pin only
module jumper_option_decoder #(
	parameter SECOND_CYCLES = `SECOND_CYCLES
) (
	input wire clock,
	input wire nrst,
	input wire [3:0] idStrap_n,
	input wire autoStartStrap_n,
	input wire autoDelayStrap_n,
	input wire auxAutoStart_n,
	input wire writeProtectStrap_n,
	input wire noNegotiateStrap_n,
	input wire noParityStrap_n,
	input wire noAttentionStrap_n,
	input wire connectorVariant,
	input wire cmdValid,
	input wire cmdModifiesMedia,
	input wire startUnitCmd,
	input wire stopUnitCmd,
	input wire busReset,
	input wire parityErrorRaw,
	input wire unitAttentionRaw,
	output reg [3:0] targetId,
	output reg autoSpinMode,
	output reg [3:0] delayMultiplier,
	output reg motorStart,
	output reg mediaReady,
	output reg cmdAccept,
	output reg cmdRefuseProtect,
	output reg targetNegotiateEn,
	output reg parityError,
	output reg unitAttentionSet,
	output reg unitAttentionClear
);
	// ------------------------------------------------------------
	// Strap synchronisation, grounded strap reads as asserted
	// ------------------------------------------------------------
	wire [11:0] syncIn;
	wire [11:0] syncOut;
	assign syncIn = ~{idStrap_n, autoStartStrap_n, autoDelayStrap_n,
		auxAutoStart_n, writeProtectStrap_n, noNegotiateStrap_n,
		noParityStrap_n, noAttentionStrap_n, connectorVariant};
	strap_sync #(.WIDTH(12)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.din(syncIn),
		.dout(syncOut)
	);
	// Synchronised strap fields
	wire [3:0] idOn = syncOut[11:8];
	wire startOn = syncOut[7];
	wire delayOn = syncOut[6];
	wire auxOn = syncOut[5];
	wire protectOn = syncOut[4];
	wire noNegOn = syncOut[3];
	wire noParOn = syncOut[2];
	wire noAttnOn = syncOut[1];
	// Grounded variant pin selects the 80-pin decode
	wire variant = syncOut[0];

	// ------------------------------------------------------------
	// Spin-up decode per connector variant
	// ------------------------------------------------------------
	// Returns {auto, multiplier}
	function [4:0] decodeSpin;
		input v;
		input st;
		input dl;
		input aux;
		begin
			if (v == `VARIANT_68) begin
				if (dl && st)
					decodeSpin = {1'b1, `MULT_FOUR};
				else if (dl)
					decodeSpin = {1'b1, `MULT_TEN};
				// Aux pin exists only on the 68-pin connector
				else if (st || aux)
					decodeSpin = {1'b1, `MULT_ZERO};
				else
					decodeSpin = {1'b0, `MULT_ZERO};
			end else begin
				if (dl && !st)
					decodeSpin = {1'b1, `MULT_TEN};
				else if (!dl && !st)
					decodeSpin = {1'b1, `MULT_ZERO};
				// Start strap, with or without delay: no multiplier, so no auto spin-up
				else
					decodeSpin = {1'b0, `MULT_ZERO};
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Latch ID and spin-up settings once after reset release
	// ------------------------------------------------------------
	reg [1:0] settle;
	reg latched;
	wire [4:0] spinCode = decodeSpin(variant, startOn, delayOn, auxOn);
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			settle <= 2'h0;
			latched <= 1'b0;
			targetId <= 4'h0;
			autoSpinMode <= 1'b0;
			delayMultiplier <= 4'h0;
		end else if (!latched) begin
			// Two sync stages and the settle count precede the latch
			if (settle != `SETTLE_LAST) begin
				settle <= settle + 2'h1;
			end else begin
				latched <= 1'b1;
				targetId <= idOn;
				autoSpinMode <= spinCode[4];
				delayMultiplier <= spinCode[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Spin-up sequencer: delay of multiplier times ID seconds
	// ------------------------------------------------------------
	reg [1:0] spinState;
	reg [7:0] secLeft;
	reg [31:0] tick;
	wire [7:0] delaySecs = {4'h0, delayMultiplier} * {4'h0, targetId};
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			spinState <= `SPIN_IDLE;
			secLeft <= 8'h0;
			tick <= 32'h0;
			motorStart <= 1'b0;
			mediaReady <= 1'b0;
		end else begin
			case (spinState)
			`SPIN_IDLE: begin
				if (startUnitCmd) begin
					spinState <= `SPIN_RUN;
				end else if (latched && autoSpinMode) begin
					secLeft <= delaySecs;
					tick <= 32'h0;
					spinState <= `SPIN_WAIT;
				end
			end
			`SPIN_WAIT: begin
				// A start unit command cuts the hold-off short
				if (startUnitCmd || secLeft == 8'h0) begin
					spinState <= `SPIN_RUN;
				// One second every SECOND_CYCLES clocks
				end else if (tick == SECOND_CYCLES - 1) begin
					tick <= 32'h0;
					secLeft <= secLeft - 8'h1;
				end else begin
					tick <= tick + 32'h1;
				end
			end
			`SPIN_RUN: begin
				if (stopUnitCmd) begin
					spinState <= `SPIN_STOP;
				end
			end
			`SPIN_STOP: begin
				// Stopped by command; only start unit restarts
				if (startUnitCmd)
					spinState <= `SPIN_RUN;
			end
			default: begin
				spinState <= `SPIN_IDLE;
			end
			endcase
			motorStart <= (spinState == `SPIN_RUN);
			mediaReady <= (spinState == `SPIN_RUN) && motorStart;
		end
	end

	// ------------------------------------------------------------
	// Per-command gates and option outputs
	// ------------------------------------------------------------
	// Set by power-on reset, cleared once straps are latched
	reg porPending;
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmdAccept <= 1'b0;
			cmdRefuseProtect <= 1'b0;
			targetNegotiateEn <= 1'b0;
			parityError <= 1'b0;
			unitAttentionSet <= 1'b0;
			unitAttentionClear <= 1'b0;
			porPending <= 1'b1;
		end else begin
			// Protect strap looked at on each command
			cmdRefuseProtect <= cmdValid && cmdModifiesMedia && protectOn;
			cmdAccept <= cmdValid && !(cmdModifiesMedia && protectOn);
			targetNegotiateEn <= !noNegOn;
			parityError <= parityErrorRaw && !noParOn;
			// Build Unit Attention after a reset unless disabled
			unitAttentionSet <= (unitAttentionRaw || porPending || busReset)
				&& !noAttnOn && latched;
			// Disabled: pending conditions are discarded instead
			unitAttentionClear <= noAttnOn && latched
				&& (porPending || busReset);
			if (latched)
				porPending <= 1'b0;
		end
	end
endmodule // jumper_option_decoder

// ===== sim/jumper_option_sva.sv
`timescale 1ns/1ps
// --------------------------------
// Strap and command checks
// --------------------------------
module jumper_option_sva (
	input wire clock,
	input wire nrst,
	input wire writeProtectStrap_n,
	input wire noNegotiateStrap_n,
	input wire noParityStrap_n,
	input wire noAttentionStrap_n,
	input wire cmdValid,
	input wire cmdModifiesMedia,
	input wire startUnitCmd,
	input wire busReset,
	input wire parityErrorRaw,
	input wire autoSpinMode,
	input wire motorStart,
	input wire cmdAccept,
	input wire cmdRefuseProtect,
	input wire targetNegotiateEn,
	input wire parityError,
	input wire unitAttentionSet,
	input wire unitAttentionClear
);
	reg [3:0] cnt;
	reg [2:0] wpH, ngH, paH, atH;
	wire ok = &cnt;
	wire wpLo = ok & ~|{wpH, writeProtectStrap_n};
	wire wpHi = ok & (&{wpH, writeProtectStrap_n});
	wire ngLo = ok & ~|{ngH, noNegotiateStrap_n};
	wire paLo = ok & ~|{paH, noParityStrap_n};
	wire atLo = ok & ~|{atH, noAttentionStrap_n};
	wire ngHi = ok & (&{ngH, noNegotiateStrap_n});
	wire paHi = ok & (&{paH, noParityStrap_n});
	wire atHi = ok & (&{atH, noAttentionStrap_n});
	// Straps count once synchronised and latched
	always @(posedge clock or negedge nrst) begin
		if (!nrst) cnt <= 4'h0;
		else if (!ok) cnt <= cnt + 4'h1;
	end
	always @(posedge clock) begin
		wpH <= {wpH[1:0], writeProtectStrap_n};
		ngH <= {ngH[1:0], noNegotiateStrap_n};
		paH <= {paH[1:0], noParityStrap_n};
		atH <= {atH[1:0], noAttentionStrap_n};
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_REFUSE: assert property (
		wpLo && cmdValid && cmdModifiesMedia |=> cmdRefuseProtect && !cmdAccept)
		else $error("write not refused");
	AST_ACCEPT: assert property (
		wpHi && cmdValid |=> cmdAccept && !cmdRefuseProtect)
		else $error("command not accepted");
	AST_NOCMD: assert property (
		ok && !cmdValid |=> !cmdAccept && !cmdRefuseProtect)
		else $error("answer without command");
	AST_PARITY: assert property (paLo |=> !parityError)
		else $error("parity flagged");
	AST_NEG: assert property (ngLo |=> !targetNegotiateEn)
		else $error("negotiation enabled");
	AST_UASET: assert property (atLo |=> !unitAttentionSet)
		else $error("attention built");
	AST_UACLR: assert property (
		atLo && busReset |-> ##[1:2] unitAttentionClear)
		else $error("attention not cleared");
	AST_MANUAL: assert property (
		ok && !autoSpinMode && !motorStart && !startUnitCmd
		&& !$past(startUnitCmd) |=> !motorStart)
		else $error("motor started unasked");
	AST_NEG_ON: assert property (ngHi |=> targetNegotiateEn)
		else $error("negotiation not enabled");
	AST_PARITY_ON: assert property (
		paHi |=> parityError == $past(parityErrorRaw))
		else $error("parity not flagged");
	AST_UA_ON: assert property (
		atHi && busReset |=> unitAttentionSet && !unitAttentionClear)
		else $error("attention not built");
endmodule // jumper_option_sva

bind jumper_option_decoder jumper_option_sva u_jumper_option_sva (.*);

// ===== sim/strap_model.sv
`timescale 1ns/1ps
module strap_model (
	input wire [11:0] fit,
	output wire [11:0] pins
);
	// Fitted straps ground the pin; aux floats high unless used alone on 68-pin
	assign pins = ~{fit[11:6], fit[5] & ~|fit[7:6] & ~fit[0], fit[4:0]};
endmodule // strap_model

// ===== sim/tb_jumper_option_decoder.sv
`timescale 1ns/1ps
module tb_jumper_option_decoder;
	localparam SC = 10;
	reg clock = 1'b0, nrst = 1'b0, cmdValid = 1'b0, cmdModifiesMedia = 1'b0;
	reg startUnitCmd = 1'b0, stopUnitCmd = 1'b0, busReset = 1'b0;
	reg parityErrorRaw = 1'b0, unitAttentionRaw = 1'b0, m, w;
	reg [11:0] fit = 12'h000;
	reg [1:0] q[$];
	reg [4:0] e;
	reg [3:0] id;
	wire [11:0] pins;
	wire [3:0] idStrap_n, targetId, delayMultiplier;
	wire autoStartStrap_n, autoDelayStrap_n, auxAutoStart_n, connectorVariant;
	wire writeProtectStrap_n, noNegotiateStrap_n, noParityStrap_n;
	wire noAttentionStrap_n, autoSpinMode, motorStart, mediaReady, cmdAccept;
	wire cmdRefuseProtect, targetNegotiateEn, parityError, unitAttentionSet;
	wire unitAttentionClear;
	integer seed = 16, n_fail = 0, checks_done = 0, cyc = 0, i, k, n, r, lim;
	assign {idStrap_n, autoStartStrap_n, autoDelayStrap_n, auxAutoStart_n,
		writeProtectStrap_n, noNegotiateStrap_n, noParityStrap_n,
		noAttentionStrap_n, connectorVariant} = pins;
	strap_model u_strap_model (.fit(fit), .pins(pins));
	jumper_option_decoder #(.SECOND_CYCLES(SC)) u_jumper_option_decoder (.*);
	always #4 clock = ~clock;
	task chk(input [8:0] ex, input [8:0] got);
		checks_done = checks_done + 1;
		if (got !== ex) begin
			n_fail = n_fail + 1;
			$display("mismatch t=%0t exp=%h got=%h", $time, ex, got);
		end
	endtask
	task give_verdict;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Spin-up decode {auto, multiplier} from {80-pin, start, delay, aux}
	function [4:0] spin(input [3:0] c);
		case (c)
			4'h1, 4'h4, 4'h8: spin = 5'h10;
			4'h2, 4'ha: spin = 5'h1a;
			4'h6: spin = 5'h14;
			default: spin = 5'h00;
		endcase
	endfunction
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cmdAccept | cmdRefuseProtect) chk(q.pop_front(), {cmdAccept, cmdRefuseProtect});
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	end
	initial begin
		for (i = 0; i < 16; i = i + 1) begin
			@(posedge clock);
			r = $random(seed);
			id = r[7:4];
			nrst <= 1'b0;
			fit <= {id, i[2:0], r[3:0], i[3]};
			e = spin({i[3:1], i[0] & ~|i[3:1]});
			repeat (5) @(posedge clock);
			nrst <= 1'b1;
			lim = e[4] ? e[3:0] * id * SC : 0;
			n = 0;
			while (!motorStart && n < lim + 20) begin
				@(posedge clock);
				n = n + 1;
			end
			chk(e[4], motorStart);
			if (e[4]) chk(1, n >= lim && n <= lim + 12);
			chk({id, e[4]}, {targetId, autoSpinMode});
			if (e[4]) chk(e[3:0], delayMultiplier);
			chk(!fit[3], targetNegotiateEn);
			chk(parityErrorRaw & !fit[2], parityError);
			if (!e[4]) begin
				startUnitCmd <= 1'b1;
				@(posedge clock);
				startUnitCmd <= 1'b0;
				repeat (4) @(posedge clock);
				chk(2'b11, {motorStart, mediaReady});
				stopUnitCmd <= 1'b1;
				@(posedge clock);
				stopUnitCmd <= 1'b0;
				repeat (4) @(posedge clock);
				chk(2'b00, {motorStart, mediaReady});
			end
			for (k = 0; k < 4; k = k + 1) begin
				r = $random(seed);
				w = r[0];
				m = r[1];
				fit[4] <= w;
				repeat (3) @(posedge clock);
				q.push_back(m & w ? 2'b01 : 2'b10);
				cmdModifiesMedia <= m;
				cmdValid <= 1'b1;
				busReset <= k == 1;
				parityErrorRaw <= r[2];
				@(posedge clock);
				cmdValid <= 1'b0;
				busReset <= 1'b0;
			end
			repeat (3) @(posedge clock);
		end
		chk(0, q.size());
		give_verdict;
	end
endmodule // tb_jumper_option_decoder
